// >>> src/hmic_top.sv
module hmic_top
    import hmic_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int TREE_N = 8
)
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [LIMIT_N-1:0] limit_evt,
    input wire logic loop_tick,
    output logic monitor_run,
    input wire logic board_temp_alert_n,
    input wire logic mgmt_irq_chain_in_n,
    input wire logic case_open_i,
    output logic case_open_o,
    output logic case_open_oe,
    input wire logic sys_mgmt_irq_out_n_i,
    output logic sys_mgmt_irq_out_n_o,
    output logic sys_mgmt_irq_out_n_oe,
    output logic host_irq_o,
    output logic host_irq_oe,
    output logic reset_out_n_o,
    output logic reset_out_n_oe,
    output logic power_hold_n,
    input wire logic [TREE_N-1:0] tree_pin_in,
    output logic nand_tree_out,
    output logic tree_hiz
);
    localparam int SW = TREE_N + 4;

    if (PULSE_CYCLES < 1 || TREE_N < 1 || NTREE_LAT > NTREE_CYC)
    begin : g_chk
        $error("hmic_top: parameter out of range");
    end

    logic [SW-1:0] sy1_r;
    logic [SW-1:0] sy2_r;
    logic bt_n_s;
    logic chain_n_s;
    logic case_s;
    logic smi_pin_s;
    logic [7:0] cfg_r;
    logic [7:0] ist1_r;
    logic [7:0] ist2_r;
    logic [7:0] ist1_nxt;
    logic [7:0] ist2_nxt;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] smim1_r;
    logic [7:0] smim2_r;
    logic [7:0] irqm1_r;
    logic [7:0] irqm2_r;
    logic run;
    logic lvl_tick;
    logic smi_act_r;
    logic irq_act_r;
    logic tree_en;
    logic nand_r;
    logic case_busy;
    logic rst_busy;
    logic ram_ovf;
    logic [4:0] ram_ptr;
    logic [7:0] ram_data;
    hmic_wst_t wst_r;
    hmic_rdst_t rdst_r;
    logic aw_v_r;
    logic w_v_r;
    logic [7:0] aw_idx_r;
    logic [7:0] w_byte_r;
    logic w_en_r;
    logic do_wr;
    logic wr_hit;
    logic [1:0] bresp_r;
    logic rd_go;
    logic [7:0] ar_idx;
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_cfg;
    logic case_go;
    logic rst_go;

    // Pins come from outside; two stages before any use
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sy1_r <= '1;
            sy2_r <= '1;
        end
        else
        begin
            sy1_r <= {tree_pin_in, sys_mgmt_irq_out_n_i, case_open_i,
                      mgmt_irq_chain_in_n, board_temp_alert_n};
            sy2_r <= sy1_r;
        end
    end

    assign bt_n_s = sy2_r[0];
    assign chain_n_s = sy2_r[1];
    assign case_s = sy2_r[2];
    assign smi_pin_s = sy2_r[3];

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_v_r && wst_r == WS_IDLE;
    assign s_axi_wready = !w_v_r && wst_r == WS_IDLE;
    assign do_wr = aw_v_r && w_v_r && wst_r == WS_IDLE;
    assign wr_hit = do_wr && w_en_r && hmic_mapped(aw_idx_r);

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            aw_v_r <= 1'b0;
            aw_idx_r <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_v_r <= 1'b1;
            aw_idx_r <= hmic_idx(s_axi_awaddr);
        end
        else if (do_wr)
            aw_v_r <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            w_v_r <= 1'b0;
            w_byte_r <= 8'h00;
            w_en_r <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_v_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_en_r <= s_axi_wstrb[0];
        end
        else if (do_wr)
            w_v_r <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wst_r <= WS_IDLE;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            case (wst_r)
                WS_IDLE:
                begin
                    if (do_wr)
                    begin
                        wst_r <= WS_RESP;
                        bresp_r <= hmic_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WS_RESP:
                begin
                    if (s_axi_bready)
                        wst_r <= WS_IDLE;
                end
                default:
                    wst_r <= WS_IDLE;
            endcase
        end
    end

    assign s_axi_bvalid = (wst_r == WS_RESP);
    assign s_axi_bresp = bresp_r;

    // Read channel: answer one cycle after the address is taken
    assign s_axi_arready = (rdst_r == RS_IDLE);
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign ar_idx = hmic_idx(s_axi_araddr);

    always_comb
    begin
        case (ar_idx)
            IDX_CFG: rdata_nxt = {cfg_r[7:5], rst_busy, cfg_r[3:0]};
            IDX_IST1: rdata_nxt = ist1_r;
            IDX_IST2: rdata_nxt = ist2_r;
            IDX_SMIM1: rdata_nxt = smim1_r;
            IDX_SMIM2: rdata_nxt = smim2_r;
            IDX_IRQM1: rdata_nxt = irqm1_r;
            IDX_IRQM2: rdata_nxt = {case_busy, irqm2_r[6:0]};
            IDX_RAMIDX: rdata_nxt = {3'h0, ram_ptr};
            IDX_RAMDAT: rdata_nxt = ram_data;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rdst_r <= RS_IDLE;
            rdata_r <= 8'h00;
            rresp_r <= RESP_OKAY;
        end
        else
        begin
            case (rdst_r)
                RS_IDLE:
                begin
                    if (rd_go)
                    begin
                        rdst_r <= RS_DATA;
                        rdata_r <= rdata_nxt;
                        rresp_r <= hmic_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                RS_DATA:
                begin
                    if (s_axi_rready)
                        rdst_r <= RS_IDLE;
                end
                default:
                    rdst_r <= RS_IDLE;
            endcase
        end
    end

    assign s_axi_rvalid = (rdst_r == RS_DATA);
    assign s_axi_rdata = {24'h000000, rdata_r};
    assign s_axi_rresp = rresp_r;

    // Control and mask registers
    assign wr_cfg = wr_hit && aw_idx_r == IDX_CFG;
    assign case_go = wr_hit && aw_idx_r == IDX_IRQM2 && w_byte_r[M2_PULSE];
    assign rst_go = wr_cfg && w_byte_r[CFG_RSTPLS] && smim2_r[M2_PULSE];

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cfg_r <= CFG_RST;
        else if (wr_cfg)
            cfg_r <= w_byte_r & CFG_WMASK;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            smim1_r <= 8'h00;
            smim2_r <= 8'h00;
            irqm1_r <= 8'h00;
            irqm2_r <= IRQM2_RST;
        end
        else if (wr_hit)
        begin
            if (aw_idx_r == IDX_SMIM1)
                smim1_r <= w_byte_r;
            if (aw_idx_r == IDX_SMIM2)
                smim2_r <= w_byte_r;
            if (aw_idx_r == IDX_IRQM1)
                irqm1_r <= w_byte_r;
            if (aw_idx_r == IDX_IRQM2)
                irqm2_r <= w_byte_r & M2_WMASK;
        end
    end

    // Loop runs only when started and line clear is low
    assign run = cfg_r[CFG_START] && !cfg_r[CFG_INTCLR];
    assign monitor_run = run;
    assign lvl_tick = loop_tick && run;

    // Level sources are sampled on each loop pass, so a read clear sticks until then
    always_comb
    begin
        set1 = run ? limit_evt[7:0] : 8'h00;
        set2 = 8'h00;
        set2[2:0] = run ? limit_evt[LIMIT_N-1:8] : 3'h0;
        set2[ST2_CASE] = lvl_tick && case_s;
        set2[ST2_BTEMP] = lvl_tick && !bt_n_s;
        set2[ST2_CHAIN] = lvl_tick && !chain_n_s;
        set2[ST2_OVF] = ram_ovf;
    end

    // Set wins over the clear of the same read
    always_comb
    begin
        ist1_nxt = (rd_go && ar_idx == IDX_IST1) ? 8'h00 : ist1_r;
        ist2_nxt = (rd_go && ar_idx == IDX_IST2) ? 8'h00 : ist2_r;
        ist1_nxt = ist1_nxt | set1;
        ist2_nxt = ist2_nxt | set2;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ist1_r <= 8'h00;
            ist2_r <= 8'h00;
        end
        else
        begin
            ist1_r <= ist1_nxt;
            ist2_r <= ist2_nxt;
        end
    end

    // Outputs follow the status directly, so a cleared register drops them
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            smi_act_r <= 1'b0;
            irq_act_r <= 1'b0;
        end
        else
        begin
            smi_act_r <= hmic_pend(ist1_r, ist2_r, smim1_r, smim2_r)
                && cfg_r[CFG_SMI_EN] && !cfg_r[CFG_INTCLR];
            irq_act_r <= hmic_pend(ist1_r, ist2_r, irqm1_r, irqm2_r)
                && cfg_r[CFG_IRQ_EN] && !cfg_r[CFG_INTCLR];
        end
    end

    assign sys_mgmt_irq_out_n_o = 1'b0;
    assign sys_mgmt_irq_out_n_oe = smi_act_r;
    assign host_irq_o = irq_act_r ^ cfg_r[CFG_IRQ_MODE];
    assign host_irq_oe = !tree_hiz;

    // Timed pulses on the case-open and reset lines
    hmic_pulse #(.CYCLES(PULSE_CYCLES)) u_case_pulse
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .start(case_go),
        .active(case_busy)
    );

    hmic_pulse #(.CYCLES(PULSE_CYCLES)) u_rst_pulse
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .start(rst_go),
        .active(rst_busy)
    );

    assign case_open_o = 1'b0;
    assign case_open_oe = case_busy && !tree_hiz;
    assign reset_out_n_o = 1'b0;
    assign reset_out_n_oe = rst_busy;
    assign power_hold_n = !cfg_r[CFG_PHOLD];

    // Self-test code capture and readback
    hmic_selftest_code_ram #(.DEPTH(RAM_DEPTH)) u_ram
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .cap_we(wr_hit && (aw_idx_r == IDX_CAPT0 || aw_idx_r == IDX_CAPT1)),
        .cap_data(w_byte_r),
        .cap_ovf(ram_ovf),
        .rd_load(wr_hit && aw_idx_r == IDX_RAMIDX),
        .rd_idx(w_byte_r[4:0]),
        .dat_acc((wr_hit && aw_idx_r == IDX_RAMDAT) || (rd_go && ar_idx == IDX_RAMDAT)),
        .dat_we(wr_hit && aw_idx_r == IDX_RAMDAT),
        .dat_wdata(w_byte_r),
        .rd_ptr(ram_ptr),
        .rd_data(ram_data)
    );

    // Board test: the tree is a registered NAND of the synchronised pins other than the management IRQ pin
    assign tree_en = !cfg_r[CFG_START] && cfg_r[CFG_INTCLR] && !smi_pin_s && !smi_act_r;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            tree_hiz <= 1'b0;
            nand_r <= 1'b0;
        end
        else
        begin
            tree_hiz <= tree_en;
            nand_r <= ~&{sy2_r[SW-1:4], case_s, chain_n_s, bt_n_s};
        end
    end

    assign nand_tree_out = nand_r;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    int case_len_r;
    always_ff @(posedge ref_clk)
    begin
        if (srst || !case_busy)
            case_len_r <= 0;
        else
            case_len_r <= case_len_r + 1;
    end

    AST_LIMIT_SET: assert property (run && limit_evt[0] |=> ist1_r[0])
        else $error("limit event lost");
    AST_POST_OVF: assert property (ram_ovf |=> ist2_r[ST2_OVF])
        else $error("overflow not recorded");
    AST_BTEMP: assert property (lvl_tick && !bt_n_s |=> ist2_r[ST2_BTEMP])
        else $error("board temp source lost");
    AST_CASE_SRC: assert property (lvl_tick && case_s |=> ist2_r[ST2_CASE])
        else $error("case-open source lost");
    AST_CASE_LEN: assert property ($fell(case_busy) |-> case_len_r == PULSE_CYCLES)
        else $error("case-open pulse length wrong");
    AST_CHAIN: assert property (lvl_tick && !chain_n_s |=> ist2_r[ST2_CHAIN])
        else $error("chained source lost");
    AST_RD_DATA: assert property (rd_go && ar_idx == IDX_IST1 && set1 == 8'h00
        |=> s_axi_rvalid && rdata_r == $past(ist1_r) && ist1_r == 8'h00)
        else $error("status read or clear wrong");
    AST_INT_CLR: assert property (cfg_r[CFG_INTCLR] |=> !smi_act_r && !irq_act_r)
        else $error("outputs active under line clear");
    AST_PHOLD: assert property (wr_cfg && w_byte_r[CFG_PHOLD] |=> !power_hold_n)
        else $error("power hold not driven");
    AST_RST_GATE: assert property (rst_go |-> smim2_r[M2_PULSE])
        else $error("reset pulse without enable");
    AST_RST_PULSE: assert property (rst_go && !rst_busy
        |=> (reset_out_n_oe && (ar_idx != IDX_CFG || rdata_nxt[CFG_RSTPLS]))[*8])
        else $error("reset pulse too short");
    AST_IRQ_OUT: assert property (hmic_pend(ist1_r, ist2_r, smim1_r, smim2_r)
        && cfg_r[CFG_SMI_EN] && !cfg_r[CFG_INTCLR] |=> sys_mgmt_irq_out_n_oe)
        else $error("unmasked status did not assert output");
    AST_TREE_HIZ: assert property (tree_hiz |-> !case_open_oe && !host_irq_oe)
        else $error("pin driven in tree mode");
    AST_NTREE: assert property (!$past(srst, 1) && !$past(srst, 2) && !$past(srst, 3)
        |-> nand_tree_out == ~&{$past(tree_pin_in, 3), $past(case_open_i, 3),
            $past(mgmt_irq_chain_in_n, 3), $past(board_temp_alert_n, 3)})
        else $error("tree output late or wrong");

    COV_RD_CLR: cover property (rd_go && ar_idx == IDX_IST1 && ist1_r != 8'h00);
    COV_CASE: cover property ($fell(case_busy));
    COV_OVF: cover property (ram_ovf);
    COV_TREE: cover property (tree_hiz);
endmodule

// >>> src/hmic_pkg.sv
package hmic_pkg;
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_CFG = 8'h40;
    localparam logic [7:0] IDX_IST1 = 8'h41;
    localparam logic [7:0] IDX_IST2 = 8'h42;
    localparam logic [7:0] IDX_SMIM1 = 8'h43;
    localparam logic [7:0] IDX_SMIM2 = 8'h44;
    localparam logic [7:0] IDX_IRQM1 = 8'h45;
    localparam logic [7:0] IDX_IRQM2 = 8'h46;
    localparam logic [7:0] IDX_CAPT0 = 8'h50;
    localparam logic [7:0] IDX_CAPT1 = 8'h54;
    localparam logic [7:0] IDX_RAMIDX = 8'h55;
    localparam logic [7:0] IDX_RAMDAT = 8'h56;
    localparam logic [7:0] CFG_RST = 8'h08;
    localparam logic [7:0] IRQM2_RST = 8'h40;
    localparam logic [7:0] CFG_WMASK = 8'h6F;
    localparam logic [7:0] M2_WMASK = 8'h7F;
    localparam int CFG_START = 0;
    localparam int CFG_SMI_EN = 1;
    localparam int CFG_IRQ_EN = 2;
    localparam int CFG_INTCLR = 3;
    localparam int CFG_RSTPLS = 4;
    localparam int CFG_IRQ_MODE = 5;
    localparam int CFG_PHOLD = 6;
    localparam int M2_PULSE = 7;
    localparam int ST2_CASE = 3;
    localparam int ST2_BTEMP = 4;
    localparam int ST2_CHAIN = 5;
    localparam int ST2_OVF = 6;
    localparam int LIMIT_N = 11;
    localparam int RAM_DEPTH = 32;
    localparam int CLK_NS = 40;
    localparam int PULSE_MS = 20;
    localparam int PULSE_CYC = (PULSE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int NTREE_NS = 200;
    localparam int NTREE_CYC = NTREE_NS / CLK_NS;
    localparam int NTREE_LAT = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {WS_IDLE = 1'b0, WS_RESP = 1'b1} hmic_wst_t;
    typedef enum logic [0:0] {RS_IDLE = 1'b0, RS_DATA = 1'b1} hmic_rdst_t;

    function automatic logic [7:0] hmic_idx(input logic [ADDR_W-1:0] a);
        hmic_idx = a[ADDR_W-1:2];
    endfunction

    function automatic logic hmic_mapped(input logic [7:0] i);
        hmic_mapped = (i >= IDX_CFG && i <= IDX_IRQM2) || i == IDX_CAPT0
            || (i >= IDX_CAPT1 && i <= IDX_RAMDAT);
    endfunction

    function automatic logic hmic_pend(input logic [7:0] s1, input logic [7:0] s2,
        input logic [7:0] m1, input logic [7:0] m2);
        hmic_pend = (|(s1 & ~m1)) || (|(s2[6:0] & ~m2[6:0]));
    endfunction
endpackage

// >>> src/hmic_pulse.sv
module hmic_pulse
    import hmic_pkg::*;
#(
    parameter int CYCLES = PULSE_CYC
)
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic start,
    output logic active
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_r;

    if (CYCLES < 1)
    begin : g_chk
        $error("hmic_pulse: CYCLES below one");
    end

    // Retrigger while running is ignored, so a pulse never stretches
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cnt_r <= '0;
        else if (start && cnt_r == '0)
            cnt_r <= CW'(CYCLES);
        else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
    end

    assign active = (cnt_r != '0);
endmodule

// >>> src/hmic_selftest_code_ram.sv
module hmic_selftest_code_ram
    import hmic_pkg::*;
#(
    parameter int DEPTH = RAM_DEPTH
)
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cap_we,
    input wire logic [7:0] cap_data,
    output logic cap_ovf,
    input wire logic rd_load,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    input wire logic dat_acc,
    input wire logic dat_we,
    input wire logic [7:0] dat_wdata,
    output logic [$clog2(DEPTH)-1:0] rd_ptr,
    output logic [7:0] rd_data
);
    localparam int PW = $clog2(DEPTH);
    logic [7:0] mem [DEPTH];
    logic [PW:0] wptr_r;
    logic [PW-1:0] rptr_r;
    logic full;

    if (DEPTH < 2 || (1 << PW) != DEPTH)
    begin : g_chk
        $error("hmic_selftest_code_ram: DEPTH must be a power of two");
    end

    assign full = wptr_r[PW];

    always_ff @(posedge ref_clk)
    begin
        if (cap_we && !full)
            mem[wptr_r[PW-1:0]] <= cap_data;
        else if (dat_we)
            mem[rptr_r] <= dat_wdata;
    end

    // Capture pointer parks at full; no wrap, so early codes survive
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            wptr_r <= '0;
        else if (cap_we && !full)
            wptr_r <= wptr_r + 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cap_ovf <= 1'b0;
        else
            cap_ovf <= cap_we && full;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            rptr_r <= '0;
        else if (rd_load)
            rptr_r <= rd_idx;
        else if (dat_acc && rptr_r != '1)
            rptr_r <= rptr_r + 1'b1;
    end

    assign rd_ptr = rptr_r;
    assign rd_data = mem[rptr_r];
endmodule

// >>> testbench/hmic_host_model.sv
module hmic_host_model (
    input wire logic ref_clk,
    input wire logic smi_oe,
    input wire logic smi_hold_low,
    input wire logic case_oe,
    input wire logic intrude,
    output logic smi_pin_n,
    output logic case_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic latch_r = '0;
    // Detector keeps the intrusion until the device pulls the line low
    always_ff @(posedge ref_clk)
        if (case_oe)
            latch_r <= '0;
        else if (intrude)
            latch_r <= '1;
    assign case_pin = latch_r & !case_oe;
    // Pull-up on the management line; tester may hold it low
    assign smi_pin_n = !(smi_oe | smi_hold_low);
endmodule

// >>> testbench/testbench.sv
module testbench
    import hmic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC = 16;
    logic ref_clk = '0;
    logic srst = '1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
    logic s_axi_rready = '0, loop_tick = '0, board_temp_alert_n = '1, mgmt_irq_chain_in_n = '1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, monitor_run;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic case_open_i, case_open_o, case_open_oe, sys_mgmt_irq_out_n_i, sys_mgmt_irq_out_n_o;
    logic sys_mgmt_irq_out_n_oe, host_irq_o, host_irq_oe, reset_out_n_o, reset_out_n_oe;
    logic power_hold_n, nand_tree_out, tree_hiz, intr = '0, hold = '0;
    logic [LIMIT_N-1:0] limit_evt = '0, e;
    logic [7:0] tree_pin_in = 8'hFF, v1, v2;
    logic [7:0] ram [RAM_DEPTH];
    int mismatches = 0;
    int tests_run = 0;

    hmic_top #(.PULSE_CYCLES(PC)) i_dut (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .limit_evt, .loop_tick,
        .monitor_run, .board_temp_alert_n, .mgmt_irq_chain_in_n, .case_open_i, .case_open_o,
        .case_open_oe, .sys_mgmt_irq_out_n_i, .sys_mgmt_irq_out_n_o, .sys_mgmt_irq_out_n_oe,
        .host_irq_o, .host_irq_oe, .reset_out_n_o, .reset_out_n_oe, .power_hold_n,
        .tree_pin_in, .nand_tree_out, .tree_hiz);
    hmic_host_model i_host (.ref_clk, .smi_oe(sys_mgmt_irq_out_n_oe), .smi_hold_low(hold),
        .case_oe(case_open_oe), .intrude(intr), .smi_pin_n(sys_mgmt_irq_out_n_i),
        .case_pin(case_open_i));

    always #20 ref_clk = ~ref_clk;

    task automatic final_report;
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Address and data released separately, slave may take either first
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        s_axi_bready <= '1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= '0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= '0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= '0;
    endtask

    task automatic rd(input logic [7:0] i, output logic [7:0] d, output logic [1:0] rs);
        @(posedge ref_clk);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= '1;
        s_axi_rready <= '1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= '0;
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata[7:0];
        rs = s_axi_rresp;
        s_axi_rready <= '0;
    endtask

    task automatic rc(input logic [7:0] i, input logic [7:0] x);
        logic [7:0] d;
        rd(i, d, r);
        chk(d, x);
    endtask

    task automatic rd_st;
        rd(IDX_IST1, v1, r);
        rd(IDX_IST2, v2, r);
        cyc(2);
    endtask

    task automatic fire(input logic [LIMIT_N-1:0] x);
        @(posedge ref_clk);
        limit_evt <= x;
        @(posedge ref_clk);
        limit_evt <= '0;
        cyc(3);
    endtask

    // Status pair {status2, status1}: x = overflow, chain, board temp, case
    function automatic logic [15:0] exp_st(input logic [LIMIT_N-1:0] ev, input logic [3:0] x);
        exp_st = {1'h0, x, ev};
    endfunction

    initial
    begin
        void'($urandom(26));
        repeat (5) @(posedge ref_clk);
        srst <= '0;
        rc(IDX_CFG, CFG_RST);
        rc(IDX_IRQM2, IRQM2_RST);
        wr(IDX_SMIM1, 8'hFF);
        wr(IDX_SMIM2, 8'h7F);
        wr(IDX_CFG, 8'h07);
        chk(monitor_run, 1'h1);
        repeat (3)
        begin
            e = LIMIT_N'($urandom_range(2047, 1));
            fire(e);
            chk(host_irq_o, 1'h1);
            chk(sys_mgmt_irq_out_n_oe, 1'h0);
            rd_st();
            chk({v2, v1}, exp_st(e, 4'h0));
            chk(host_irq_o, 1'h0);
            rc(IDX_IST1, 8'h00);
        end
        wr(IDX_SMIM2, 8'h5F);
        board_temp_alert_n <= '0;
        mgmt_irq_chain_in_n <= '0;
        intr <= '1;
        cyc(4);
        loop_tick <= '1;
        @(posedge ref_clk);
        loop_tick <= '0;
        board_temp_alert_n <= '1;
        mgmt_irq_chain_in_n <= '1;
        intr <= '0;
        cyc(3);
        chk(sys_mgmt_irq_out_n_oe, 1'h1);
        rd_st();
        chk({v2, v1}, exp_st('0, 4'h7));
        chk(sys_mgmt_irq_out_n_oe, 1'h0);
        wr(IDX_IRQM2, 8'hC0);
        chk(case_open_oe, 1'h1);
        rc(IDX_IRQM2, 8'hC0);
        cyc(PC);
        chk(case_open_oe, 1'h0);
        rc(IDX_IRQM2, IRQM2_RST);
        fire(11'h001);
        wr(IDX_CFG, 8'h2F);
        cyc(2);
        chk(host_irq_o, 1'h1);
        chk(monitor_run, 1'h0);
        rd_st();
        wr(IDX_CFG, 8'h47);
        chk(power_hold_n, 1'h0);
        wr(IDX_CFG, 8'h17);
        cyc(2);
        chk(reset_out_n_oe, 1'h0);
        chk(power_hold_n, 1'h1);
        rc(IDX_CFG, 8'h07);
        wr(IDX_SMIM2, 8'hFF);
        wr(IDX_CFG, 8'h17);
        chk(reset_out_n_oe, 1'h1);
        chk({case_open_o, sys_mgmt_irq_out_n_o, reset_out_n_o}, 3'h0);
        rc(IDX_CFG, 8'h17);
        cyc(PC);
        chk(reset_out_n_oe, 1'h0);
        rc(IDX_CFG, 8'h07);
        // One capture beyond the depth must neither store nor wrap
        for (int n = 0; n <= RAM_DEPTH; n++)
        begin
            v1 = 8'($urandom);
            if (n < RAM_DEPTH)
                ram[n] = v1;
            wr(n[0] ? IDX_CAPT1 : IDX_CAPT0, v1);
        end
        cyc(2);
        rc(IDX_IST2, 8'h40);
        wr(IDX_RAMIDX, 8'h00);
        chk(r, RESP_OKAY);
        for (int n = 0; n < RAM_DEPTH; n++)
            rc(IDX_RAMDAT, ram[n]);
        rc(IDX_RAMIDX, 8'h1F);
        rd(8'h60, v1, r);
        chk(r, RESP_SLVERR);
        wr(8'h60, 8'h00);
        chk(r, RESP_SLVERR);
        wr(IDX_CFG, CFG_RST);
        hold <= '1;
        intr <= '1;
        cyc(6);
        chk(tree_hiz, 1'h1);
        chk(host_irq_oe, 1'h0);
        chk(nand_tree_out, 1'h0);
        for (int n = 0; n < 8; n++)
        begin
            tree_pin_in <= ~(8'h01 << n);
            cyc(6);
            chk(nand_tree_out, 1'h1);
            tree_pin_in <= 8'hFF;
            cyc(6);
            chk(nand_tree_out, 1'h0);
        end
        final_report();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        final_report();
    end
endmodule
